//--- core/oewc_core.sv
// file: oscillator enable, source protection and stabilization wait control with register port
//
// Function
// - fast wait field bits 5-4 pick 128, 256, 512 or 1024 fast cycles.
// - internal wait field bits 7-6 pick 8, 16, 32 or 64 cycles.
// - internal wait field resets to zero, a 64-cycle wait before cpu clock.
// - fast wait field resets to zero, a 1024-cycle wait.
// - internal clock withheld until its selected wait has fully elapsed.
// - fast clock withheld after switch-on until its selected wait has elapsed.
// - fast wait applies only with fast wait-enable set; otherwise clock passes at once.
// - slow clock reaches the system after a fixed 256-cycle wait.
// - bit 2 enables internal oscillator, resets to one; reserved without it.
// - stopping the internal oscillator is ignored while it is the source.
// - bit 1 enables slow oscillator, resets to zero.
// - slow oscillator disable ignored while it is the system source.
// - bit 0 enables fast oscillator; reset one without internal, zero with it.
// - fast oscillator disable ignored while it is the system source.
// - wait-enable register: slow bit 5, fast bit 4, both reset one.
// - slow wait-enable set gives 256-cycle wait; clear gives none.
// - source change to a stopped oscillator is refused, field unchanged.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/100ps
module oewc_core
    import oewc_pkg::*;
#(
    parameter bit HAS_INTERNAL_OSC = 1'b1
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire oewc_bus_t busReq,
    output logic [7:0] busRdata,
    input wire logic fastOscClkPin,
    input wire logic slowOscClkPin,
    input wire logic intOscClkPin,
    output logic fastOscEnable,
    output logic slowOscEnable,
    output logic intOscEnable,
    output logic fastClockValid,
    output logic slowClockValid,
    output logic intClockValid,
    output logic [1:0] sysClockSource,
    output logic sysClockReady
);

    // variant-dependent reset values, constant at elaboration
    localparam logic FAST_EN_RESET = HAS_INTERNAL_OSC ? FAST_EN_RESET_WITH : FAST_EN_RESET_WITHOUT;
    localparam logic INT_EN_RESET = HAS_INTERNAL_OSC ? INT_EN_RESET_WITH : 1'b0;
    localparam logic [1:0] SRC_RESET = HAS_INTERNAL_OSC ? SRC_INT : SRC_FAST;

    logic fastEn_q;
    logic slowEn_q;
    logic intEn_q;
    logic [1:0] fastWt_q;
    logic [1:0] intWt_q;
    logic fastWce_q;
    logic slowWce_q;
    logic [1:0] src_q;
    logic [7:0] rdata_q;
    logic wrCtl;
    logic wrNfen;
    logic wrSrc;
    logic [1:0] srcReq;
    logic srcAllowed;
    logic [WAIT_W-1:0] fastWaitCycles;
    logic [WAIT_W-1:0] intWaitCycles;
    logic [7:0] ctlView;
    logic [7:0] nfenView;
    logic [7:0] srcView;

    // write decode; a strobe to any other address touches nothing
    assign wrCtl = busReq.wr && (busReq.addr == ADDR_CTL);
    assign wrNfen = busReq.wr && (busReq.addr == ADDR_NFEN);
    assign wrSrc = busReq.wr && (busReq.addr == ADDR_SRC);
    assign srcReq = busReq.wdata[SRC_HI:SRC_LO];

    // source change is legal only toward a running oscillator and a defined code
    always_comb begin
        unique case (srcReq)
            SRC_INT: srcAllowed = HAS_INTERNAL_OSC && intEn_q;
            SRC_SLOW: srcAllowed = slowEn_q;
            SRC_FAST: srcAllowed = fastEn_q;
            default: srcAllowed = 1'b0;
        endcase
    end

    // system clock source select
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            src_q <= SRC_RESET;
        end else if (wrSrc && srcAllowed) begin
            src_q <= srcReq;
        end
    end

    // fast oscillator enable; the active source cannot be turned off
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            fastEn_q <= FAST_EN_RESET;
        end else if (wrCtl) begin
            fastEn_q <= busReq.wdata[CTL_FAST_EN] | (src_q == SRC_FAST);
        end
    end

    // slow oscillator enable
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            slowEn_q <= SLOW_EN_RESET;
        end else if (wrCtl) begin
            slowEn_q <= busReq.wdata[CTL_SLOW_EN] | (src_q == SRC_SLOW);
        end
    end

    // internal oscillator enable; tied off on the variant that lacks it
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            intEn_q <= INT_EN_RESET;
        end else if (wrCtl && HAS_INTERNAL_OSC) begin
            intEn_q <= busReq.wdata[CTL_INT_EN] | (src_q == SRC_INT);
        end
    end

    // wait select fields
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            fastWt_q <= WT_RESET;
            intWt_q <= WT_RESET;
        end else if (wrCtl) begin
            fastWt_q <= busReq.wdata[CTL_FAST_WT_HI:CTL_FAST_WT_LO];
            if (HAS_INTERNAL_OSC) begin
                intWt_q <= busReq.wdata[CTL_INT_WT_HI:CTL_INT_WT_LO];
            end
        end
    end

    // wait circuit enables; a cleared bit suits an already stable external clock
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            fastWce_q <= WCE_RESET;
            slowWce_q <= WCE_RESET;
        end else if (wrNfen) begin
            fastWce_q <= busReq.wdata[NFEN_FAST_WCE];
            slowWce_q <= busReq.wdata[NFEN_SLOW_WCE];
        end
    end

    // wait code to cycle count
    always_comb begin
        unique case (fastWt_q)
            2'h3: fastWaitCycles = FAST_WAIT_3;
            2'h2: fastWaitCycles = FAST_WAIT_2;
            2'h1: fastWaitCycles = FAST_WAIT_1;
            2'h0: fastWaitCycles = FAST_WAIT_0;
        endcase
    end

    always_comb begin
        unique case (intWt_q)
            2'h3: intWaitCycles = INT_WAIT_3;
            2'h2: intWaitCycles = INT_WAIT_2;
            2'h1: intWaitCycles = INT_WAIT_1;
            2'h0: intWaitCycles = INT_WAIT_0;
        endcase
    end

    // read views; reserved positions are built as zero, so writes to them vanish
    always_comb begin
        ctlView = 8'h00;
        ctlView[CTL_FAST_EN] = fastEn_q;
        ctlView[CTL_SLOW_EN] = slowEn_q;
        ctlView[CTL_INT_EN] = HAS_INTERNAL_OSC & intEn_q;
        ctlView[CTL_FAST_WT_HI:CTL_FAST_WT_LO] = fastWt_q;
        ctlView[CTL_INT_WT_HI:CTL_INT_WT_LO] = HAS_INTERNAL_OSC ? intWt_q : 2'h0;
        nfenView = 8'h00;
        nfenView[NFEN_FAST_WCE] = fastWce_q;
        nfenView[NFEN_SLOW_WCE] = slowWce_q;
        srcView = 8'h00;
        srcView[SRC_HI:SRC_LO] = src_q;
    end

    // read data stand only in the cycle after the strobe; unmapped reads give zero
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= 8'h00;
        end else if (busReq.rd) begin
            unique case (busReq.addr)
                ADDR_CTL: rdata_q <= ctlView;
                ADDR_NFEN: rdata_q <= nfenView;
                ADDR_SRC: rdata_q <= srcView;
                default: rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign busRdata = rdata_q;
    assign fastOscEnable = fastEn_q;
    assign slowOscEnable = slowEn_q;
    assign intOscEnable = HAS_INTERNAL_OSC & intEn_q;
    assign sysClockSource = src_q;

    // one wait counter per oscillator, each counting its own sampled clock
    oewc_wait_counter fastWait (
        .mclk(mclk),
        .resetn(resetn),
        .oscEnable(fastOscEnable),
        .oscClkPin(fastOscClkPin),
        .waitEnable(fastWce_q),
        .waitCycles(fastWaitCycles),
        .clockValid(fastClockValid)
    );

    oewc_wait_counter slowWait (
        .mclk(mclk),
        .resetn(resetn),
        .oscEnable(slowOscEnable),
        .oscClkPin(slowOscClkPin),
        .waitEnable(slowWce_q),
        .waitCycles(SLOW_WAIT),
        .clockValid(slowClockValid)
    );

    // the internal counter has no wait bypass: its wait always applies
    oewc_wait_counter intWait (
        .mclk(mclk),
        .resetn(resetn),
        .oscEnable(intOscEnable),
        .oscClkPin(intOscClkPin),
        .waitEnable(1'b1),
        .waitCycles(intWaitCycles),
        .clockValid(intClockValid)
    );

    // cpu clock is ready only when the selected source has passed its wait
    always_comb begin
        unique case (src_q)
            SRC_INT: sysClockReady = intClockValid;
            SRC_SLOW: sysClockReady = slowClockValid;
            SRC_FAST: sysClockReady = fastClockValid;
            default: sysClockReady = 1'b0;
        endcase
    end

    // helper: marks the first cycle after reset release
    logic firstCycle_q;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            firstCycle_q <= 1'b1;
        end else begin
            firstCycle_q <= 1'b0;
        end
    end

    fast_wait_code_a: assert property (@(posedge mclk) disable iff (!resetn)
        (fastWt_q == 2'h3) |-> (fastWaitCycles == 11'h080 && fastWaitCycles != FAST_WAIT_0))
        else $error("fast wait code 3 does not give 128 cycles");

    int_wait_code_a: assert property (@(posedge mclk) disable iff (!resetn)
        (intWt_q == 2'h0) |-> (intWaitCycles == 11'h040))
        else $error("internal wait code 0 does not give 64 cycles");

    int_wait_reset_a: assert property (@(posedge mclk) disable iff (!resetn)
        firstCycle_q |-> (intWt_q == 2'h0 && intWaitCycles == 11'h040))
        else $error("internal wait not 64 cycles after reset");

    fast_wait_reset_a: assert property (@(posedge mclk) disable iff (!resetn)
        firstCycle_q |-> (fastWt_q == 2'h0 && fastWaitCycles == 11'h400))
        else $error("fast wait not 1024 cycles after reset");

    int_wait_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
        $rose(intOscEnable) |-> (!intClockValid) [*8])
        else $error("internal clock valid before its wait");

    fast_wait_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
        ($rose(fastOscEnable) && fastWce_q) |-> (!fastClockValid) [*8])
        else $error("fast clock valid before its wait");

    fast_bypass_a: assert property (@(posedge mclk) disable iff (!resetn)
        (fastOscEnable && $past(fastOscEnable) && !fastWce_q) |=> fastClockValid)
        else $error("fast clock not passed with wait disabled");

    slow_wait_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
        ($rose(slowOscEnable) && slowWce_q) |-> (!slowClockValid) [*8])
        else $error("slow clock valid before its wait");

    int_source_keep_a: assert property (@(posedge mclk) disable iff (!resetn)
        (HAS_INTERNAL_OSC && src_q == SRC_INT) |-> intOscEnable)
        else $error("internal oscillator stopped while it is the source");

    slow_source_keep_a: assert property (@(posedge mclk) disable iff (!resetn)
        (src_q == SRC_SLOW) |-> slowOscEnable)
        else $error("slow oscillator stopped while it is the source");

    fast_source_keep_a: assert property (@(posedge mclk) disable iff (!resetn)
        (src_q == SRC_FAST) |-> fastOscEnable)
        else $error("fast oscillator stopped while it is the source");

    wce_read_a: assert property (@(posedge mclk) disable iff (!resetn)
        (busReq.rd && busReq.addr == ADDR_NFEN) |=>
            (busRdata[3:0] == 4'h0 && busRdata[7:6] == 2'h0 &&
             busRdata[5] == $past(slowWce_q) && busRdata[4] == $past(fastWce_q)))
        else $error("wait-enable read value wrong");

    slow_bypass_a: assert property (@(posedge mclk) disable iff (!resetn)
        (slowOscEnable && $past(slowOscEnable) && !slowWce_q) |=> slowClockValid)
        else $error("slow clock not passed with wait disabled");

    src_refuse_a: assert property (@(posedge mclk) disable iff (!resetn)
        (wrSrc && !srcAllowed) |=> $stable(src_q))
        else $error("source changed to a stopped oscillator");

    ctl_reserved_a: assert property (@(posedge mclk) disable iff (!resetn)
        (busReq.rd && busReq.addr == ADDR_CTL) |=> (busRdata[3] == 1'b0))
        else $error("reserved control bit reads nonzero");

    fast_wait_mid_a: assert property (@(posedge mclk) disable iff (!resetn)
        ((fastWt_q != 2'h2) || (fastWaitCycles == 11'h100)) &&
        ((fastWt_q != 2'h1) || (fastWaitCycles == 11'h200)))
        else $error("fast wait code 2 or 1 gives a wrong count");

    int_wait_short_a: assert property (@(posedge mclk) disable iff (!resetn)
        ((intWt_q != 2'h3) || (intWaitCycles == 11'h008)) &&
        ((intWt_q != 2'h2) || (intWaitCycles == 11'h010)) &&
        ((intWt_q != 2'h1) || (intWaitCycles == 11'h020)))
        else $error("internal wait code 3, 2 or 1 gives a wrong count");

    src_code_legal_a: assert property (@(posedge mclk) disable iff (!resetn)
        (src_q != 2'h3) && (HAS_INTERNAL_OSC || (src_q != SRC_INT)))
        else $error("source select holds a code that must be refused");

    noint_reserved_a: assert property (@(posedge mclk) disable iff (!resetn)
        (!HAS_INTERNAL_OSC && busReq.rd && busReq.addr == ADDR_CTL) |=>
            (busRdata[7:6] == 2'h0 && busRdata[2] == 1'b0 && !intOscEnable))
        else $error("internal oscillator bits not reserved without that oscillator");

    fast_wait_done_c: cover property (@(posedge mclk) disable iff (!resetn)
        fastOscEnable && fastWce_q ##1 $rose(fastClockValid));

    src_change_c: cover property (@(posedge mclk) disable iff (!resetn)
        wrSrc && srcAllowed && (srcReq != src_q));

    src_refused_c: cover property (@(posedge mclk) disable iff (!resetn)
        wrSrc && !srcAllowed);

    disable_ignored_c: cover property (@(posedge mclk) disable iff (!resetn)
        wrCtl && (src_q == SRC_SLOW) && !busReq.wdata[CTL_SLOW_EN]);

    slow_wait_done_c: cover property (@(posedge mclk) disable iff (!resetn)
        slowOscEnable && slowWce_q ##1 $rose(slowClockValid));

endmodule : oewc_core

//--- core/oewc_wait_counter.sv
// file: stabilization wait counter for one oscillator, counting its sampled clock edges
`timescale 1ns/100ps
module oewc_wait_counter
    import oewc_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic oscEnable,
    input wire logic oscClkPin,
    input wire logic waitEnable,
    input wire logic [WAIT_W-1:0] waitCycles,
    output logic clockValid
);

    logic syncA_q;
    logic syncB_q;
    logic syncC_q;
    logic enPrev_q;
    logic [WAIT_W-1:0] count_q;
    logic oscEdge;
    logic enRise;

    // two-stage synchronizer; syncB and its delayed copy syncC feed the edge detector
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            syncA_q <= 1'b0;
            syncB_q <= 1'b0;
            syncC_q <= 1'b0;
        end else begin
            syncA_q <= oscClkPin;
            syncB_q <= syncA_q;
            syncC_q <= syncB_q;
        end
    end

    assign oscEdge = syncB_q & ~syncC_q;
    assign enRise = oscEnable & ~enPrev_q;

    // enable history for restart detection
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            enPrev_q <= 1'b0;
        end else begin
            enPrev_q <= oscEnable;
        end
    end

    // restart at every switch-on, then count oscillator edges up to the target
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            count_q <= '0;
        end else if (enRise) begin
            count_q <= '0;
        end else if (oscEnable && oscEdge && (count_q < waitCycles)) begin
            count_q <= count_q + 11'h001;
        end
    end

    // valid is held low during the switch-on cycle so a stale count cannot leak through
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            clockValid <= 1'b0;
        end else begin
            clockValid <= oscEnable & enPrev_q & (~waitEnable | (count_q >= waitCycles));
        end
    end

endmodule : oewc_wait_counter

//--- include/oewc_pkg.sv
// package: register map, field layout, reset values and wait counts of the oscillator control
package oewc_pkg;

    // register byte addresses
    localparam logic [15:0] ADDR_SRC = 16'h5060;
    localparam logic [15:0] ADDR_CTL = 16'h5061;
    localparam logic [15:0] ADDR_NFEN = 16'h5062;

    // oscillator control field positions
    localparam int CTL_FAST_EN = 0;
    localparam int CTL_SLOW_EN = 1;
    localparam int CTL_INT_EN = 2;
    localparam int CTL_FAST_WT_LO = 4;
    localparam int CTL_FAST_WT_HI = 5;
    localparam int CTL_INT_WT_LO = 6;
    localparam int CTL_INT_WT_HI = 7;

    // wait circuit enable field positions
    localparam int NFEN_FAST_WCE = 4;
    localparam int NFEN_SLOW_WCE = 5;

    // source select field
    localparam int SRC_LO = 0;
    localparam int SRC_HI = 1;
    localparam logic [1:0] SRC_INT = 2'h0;
    localparam logic [1:0] SRC_SLOW = 2'h1;
    localparam logic [1:0] SRC_FAST = 2'h2;

    // reset values
    localparam logic [1:0] WT_RESET = 2'h0;
    localparam logic WCE_RESET = 1'b1;
    localparam logic SLOW_EN_RESET = 1'b0;
    localparam logic INT_EN_RESET_WITH = 1'b1;
    localparam logic FAST_EN_RESET_WITH = 1'b0;
    localparam logic FAST_EN_RESET_WITHOUT = 1'b1;

    // wait cycle counts in oscillator cycles
    localparam int WAIT_W = 11;
    localparam logic [WAIT_W-1:0] FAST_WAIT_3 = 11'h080;
    localparam logic [WAIT_W-1:0] FAST_WAIT_2 = 11'h100;
    localparam logic [WAIT_W-1:0] FAST_WAIT_1 = 11'h200;
    localparam logic [WAIT_W-1:0] FAST_WAIT_0 = 11'h400;
    localparam logic [WAIT_W-1:0] INT_WAIT_3 = 11'h008;
    localparam logic [WAIT_W-1:0] INT_WAIT_2 = 11'h010;
    localparam logic [WAIT_W-1:0] INT_WAIT_1 = 11'h020;
    localparam logic [WAIT_W-1:0] INT_WAIT_0 = 11'h040;
    localparam logic [WAIT_W-1:0] SLOW_WAIT = 11'h100;

    // register port request carried as one bundle
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } oewc_bus_t;

endpackage : oewc_pkg

//--- testbench/test_oewc_core.sv
// testbench: register-level sequences for the oscillator enable and wait control block
`timescale 1ns/100ps
module test_oewc_core
    import oewc_pkg::*;
;
    localparam int P = 6; // oscillator pin period in mclk cycles, must exceed 3

    logic mclk = 1'b0;
    logic resetn = 1'b0;
    oewc_bus_t busReq = '0;
    logic [7:0] busRdata;
    logic fastOscClkPin = 1'b0;
    logic slowOscClkPin = 1'b0;
    logic intOscClkPin = 1'b0;
    logic fastOscEnable;
    logic slowOscEnable;
    logic intOscEnable;
    logic fastClockValid;
    logic slowClockValid;
    logic intClockValid;
    logic [1:0] sysClockSource;
    logic sysClockReady;
    logic [7:0] rdVal;
    logic [7:0] busRdata2;
    logic fastOscEnable2;
    logic intOscEnable2;
    logic [7:0] refusedCodes [3] = '{8'h00, 8'h01, 8'h03};
    int divCnt = 0;
    int bad_count = 0;
    int checked = 0;

    oewc_core #(.HAS_INTERNAL_OSC(1'b1)) DUT (
        .mclk(mclk),
        .resetn(resetn),
        .busReq(busReq),
        .busRdata(busRdata),
        .fastOscClkPin(fastOscClkPin),
        .slowOscClkPin(slowOscClkPin),
        .intOscClkPin(intOscClkPin),
        .fastOscEnable(fastOscEnable),
        .slowOscEnable(slowOscEnable),
        .intOscEnable(intOscEnable),
        .fastClockValid(fastClockValid),
        .slowClockValid(slowClockValid),
        .intClockValid(intClockValid),
        .sysClockSource(sysClockSource),
        .sysClockReady(sysClockReady)
    );

    // second variant without the internal oscillator, sharing the bus and the pins
    oewc_core #(.HAS_INTERNAL_OSC(1'b0)) DUT2 (
        .mclk(mclk),
        .resetn(resetn),
        .busReq(busReq),
        .busRdata(busRdata2),
        .fastOscClkPin(fastOscClkPin),
        .slowOscClkPin(slowOscClkPin),
        .intOscClkPin(intOscClkPin),
        .fastOscEnable(fastOscEnable2),
        .slowOscEnable(),
        .intOscEnable(intOscEnable2),
        .fastClockValid(),
        .slowClockValid(),
        .intClockValid(),
        .sysClockSource(),
        .sysClockReady()
    );

    // 25 MHz clock
    always #20 mclk = ~mclk;

    // oscillators run only while enabled, so a stopped one shows no edges
    always @(posedge mclk) begin
        divCnt <= (divCnt == P - 1) ? 0 : divCnt + 1;
        fastOscClkPin <= fastOscEnable && (divCnt < 3);
        slowOscClkPin <= slowOscEnable && (divCnt < 3);
        intOscClkPin <= intOscEnable && (divCnt < 3);
    end

    task automatic wrap_up();
        if (bad_count == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // one-cycle write strobe; the lowering edge leaves an idle cycle before the next access
    task automatic wr(input logic [15:0] addr, input logic [7:0] data);
        @(posedge mclk);
        busReq <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        busReq.wr <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [15:0] addr, input logic [7:0] exp, input string name);
        @(posedge mclk);
        busReq <= '{addr: addr, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        busReq.rd <= 1'b0;
        #1;
        rdVal = busRdata;
        check(name, {8'h00, rdVal}, {8'h00, exp});
    endtask : rd_chk

    function automatic logic valid_of(input int which);
        case (which)
            0: valid_of = fastClockValid;
            1: valid_of = slowClockValid;
            default: valid_of = intClockValid;
        endcase
    endfunction : valid_of

    // tolerance of one pin period covers synchronizer delay, far below a doubling of the count
    task automatic wait_valid(input int which, input int edges, input string name);
        int n;
        int lo;
        int hi;
        n = 0;
        lo = (edges - 1) * P;
        hi = (edges + 1) * P + 8;
        #1;
        while (valid_of(which) !== 1'b1 && n < hi + 10) begin
            @(posedge mclk);
            #1;
            n++;
        end
        check(name, {15'h0000, (n >= lo && n <= hi)}, 16'h0001);
    endtask : wait_valid

    // hang guard, about four times the expected run
    initial begin
        repeat (60000) @(posedge mclk);
        bad_count++;
        wrap_up();
    end

    initial begin
        repeat (8) @(posedge mclk);
        resetn <= 1'b1;
        wait_valid(2, 64, "internal wait after reset");
        check("ready after reset", {15'h0000, sysClockReady}, 16'h0001);
        rd_chk(ADDR_CTL, 8'h04, "ctl reset");
        check("ctl reset without int", {8'h00, busRdata2}, 16'h0001);
        rd_chk(ADDR_NFEN, 8'h30, "wait enable reset");
        rd_chk(ADDR_SRC, 8'h00, "source reset");
        rd_chk(16'h5063, 8'h00, "unmapped read");
        check("enables reset", {13'h0000, intOscEnable, slowOscEnable, fastOscEnable},
            16'h0004);
        check("enables without int", {14'h0000, intOscEnable2, fastOscEnable2}, 16'h0001);
        // reserved bits written as ones must read back as zero
        wr(ADDR_NFEN, 8'hFF);
        rd_chk(ADDR_NFEN, 8'h30, "wait enable reserved");
        wr(ADDR_CTL, 8'hC8);
        rd_chk(ADDR_CTL, 8'hC4, "ctl reserved and int kept");
        check("ctl reserved without int", {8'h00, busRdata2}, 16'h0001);
        check("int kept running", {15'h0000, intOscEnable}, 16'h0001);
        wr(ADDR_SRC, 8'h02);
        rd_chk(ADDR_SRC, 8'h00, "source to stopped fast");
        // every fast wait code, restarting the count on each switch-on
        for (int code = 3; code >= 0; code--) begin
            wr(ADDR_CTL, 8'h05 | 8'(code << 4));
            wait_valid(0, 128 << (3 - code), "fast wait code");
            if (code != 0) begin
                wr(ADDR_CTL, 8'h04 | 8'(code << 4));
                repeat (3) @(posedge mclk);
                #1;
                check("fast valid dropped", {15'h0000, fastClockValid}, 16'h0000);
            end
        end
        wr(ADDR_SRC, 8'h02);
        rd_chk(ADDR_SRC, 8'h02, "source to running fast");
        check("fast ready", {14'h0000, sysClockSource, sysClockReady}, 16'h0005);
        wr(ADDR_CTL, 8'h00);
        rd_chk(ADDR_CTL, 8'h01, "fast kept, int stopped");
        check("enables after stop", {13'h0000, intOscEnable, slowOscEnable, fastOscEnable},
            16'h0001);
        // refused codes: stopped internal, stopped slow and the reserved one
        foreach (refusedCodes[i]) begin
            wr(ADDR_SRC, refusedCodes[i]);
            rd_chk(ADDR_SRC, 8'h02, "source refused");
        end
        // every internal wait code
        for (int code = 3; code >= 0; code--) begin
            wr(ADDR_CTL, 8'h05 | 8'(code << 6));
            wait_valid(2, 8 << (3 - code), "internal wait code");
            wr(ADDR_CTL, 8'h01 | 8'(code << 6));
            repeat (3) @(posedge mclk);
            #1;
            check("int valid dropped", {15'h0000, intClockValid}, 16'h0000);
        end
        // slow oscillator with its fixed wait, then held while it is the source
        wr(ADDR_CTL, 8'h03);
        wait_valid(1, 256, "slow wait");
        wr(ADDR_SRC, 8'h01);
        rd_chk(ADDR_SRC, 8'h01, "source to slow");
        wr(ADDR_CTL, 8'h00);
        rd_chk(ADDR_CTL, 8'h02, "slow kept");
        repeat (3) @(posedge mclk);
        #1;
        check("fast valid off", {15'h0000, fastClockValid}, 16'h0000);
        // fast bypass: clock passes at once with its wait-enable cleared
        wr(ADDR_NFEN, 8'h20);
        rd_chk(ADDR_NFEN, 8'h20, "fast wait disabled");
        wr(ADDR_CTL, 8'h03);
        wait_valid(0, 0, "fast bypass");
        // slow bypass, after moving the source away from slow
        wr(ADDR_SRC, 8'h02);
        wr(ADDR_CTL, 8'h01);
        wr(ADDR_NFEN, 8'h00);
        rd_chk(ADDR_CTL, 8'h01, "slow stopped");
        wr(ADDR_CTL, 8'h03);
        wait_valid(1, 0, "slow bypass");
        wrap_up();
    end

endmodule : test_oewc_core
